// >>> dv/dps_host_properties.sv
// concurrent checks on the semaphore host pins and bus
module dps_host_properties #(
  parameter int DW = 18
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic semaphore_select_n,
  input wire logic ce_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [2:0] semaphore_index_lines,
  input wire logic [DW-1:0] data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff rst;
  sequence s_strobe;
    (!rw_n)[*4] ##1 rw_n;
  endsequence
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ce_off;
    !semaphore_select_n |-> ce_n;
  endproperty
  a_ce_off: assert property (p_ce_off) else $error("chip enable on in access");
  property p_setup;
    $fell(rw_n) |-> !$past(semaphore_select_n, 3) && $stable(semaphore_index_lines);
  endproperty
  a_setup: assert property (p_setup) else $error("strobe before setup");
  property p_pulse;
    $fell(rw_n) |-> s_strobe;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe length wrong");
  property p_wr_drive;
    !rw_n |-> (&data_oe) && !semaphore_select_n && oe_n;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write not driven");
  property p_rd_float;
    !oe_n |-> data_oe == '0 && rw_n;
  endproperty
  a_rd_float: assert property (p_rd_float) else $error("driving during read");
  // a read opens only from a cycle in which the select stood released
  property p_gap;
    $fell(oe_n) |-> $past(semaphore_select_n) && $past(rw_n);
  endproperty
  a_gap: assert property (p_gap) else $error("no gap between accesses");
  property p_idle;
    semaphore_select_n |-> rw_n && oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("strobe without select");
endmodule : dps_host_properties

// >>> dv/dps_sem_model.sv
// semaphore device model: host port on pins, other port through task calls
module dps_sem_model (
  input wire logic semaphore_select_n,
  input wire logic ce_n,
  input wire logic rw_n,
  input wire logic oe_n,
  input wire logic [1:0] byte_lane_selects_n,
  input wire logic [2:0] semaphore_index_lines,
  input wire logic [17:0] data_o,
  output logic [17:0] data_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // eight request latch pairs, zero requests; power-up contents are junk
  logic [7:0] req_l = 8'h5a;
  logic [7:0] req_r = 8'h3c;
  logic [7:0] own_l = 8'h00;
  logic [7:0] own_r = 8'h00;
  logic lat = 1'b1;
  logic act;
  logic busy_l_n;
  // first request wins, a tie goes to the host port; no array, nothing gated
  task automatic settle(input int i);
    if (!own_l[i] && !own_r[i]) begin
      own_l[i] = !req_l[i];
      own_r[i] = req_l[i] && !req_r[i];
    end else if (own_l[i] && req_l[i]) begin
      own_l[i] = 1'b0;
      own_r[i] = !req_r[i];
    end else if (own_r[i] && req_r[i]) begin
      own_r[i] = 1'b0;
      own_l[i] = !req_l[i];
    end
  endtask : settle
  task automatic write_r(input int i, input logic v);
    req_r[i] = v;
    settle(i);
  endtask : write_r
  function automatic logic flag_r(input int i);
    return !own_r[i];
  endfunction : flag_r
  initial begin
    for (int i = 0; i < 8; i++) begin
      settle(i);
    end
  end
  always @(posedge rw_n) begin
    if (!semaphore_select_n && ce_n) begin
      req_l[semaphore_index_lines] = data_o[0];
      settle(int'(semaphore_index_lines));
    end
  end
  assign act = !semaphore_select_n && !oe_n && byte_lane_selects_n != 2'b11;
  always @(posedge act) lat = !own_l[semaphore_index_lines];
  // far port holds the array at address 0; busy looks at enable and address only
  assign busy_l_n = ce_n || semaphore_index_lines != 3'h0;
  // outside a read the bus shows the inverse of the last value
  assign data_i = act ? {18{lat}} : {18{!lat}};
endmodule : dps_sem_model

// >>> dv/tb_dps_host.sv
// self-checking bench for the semaphore host
module tb_dps_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic busy_n_i = 1'b1;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, semaphore_select_n, ce_n, rw_n, oe_n, master_strap;
  logic [1:0] byte_lane_selects_n;
  logic [2:0] semaphore_index_lines;
  logic [17:0] data_o, data_oe, data_i;
  int n_mismatch = 0;
  int n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  dps_host i_dps_host (.*);
  dps_sem_model i_dps_sem_model (.*);
  task automatic test_done;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
    if (n >= 40) begin
      n_mismatch++;
      test_done();
    end
  endtask : wb
  // read a register until the given bit clears
  task automatic poll(input logic [3:0] adr, input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, adr, 32'h0);
      n++;
    end while (q[b] !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
      test_done();
    end
  endtask : poll
  task automatic cmd(input logic [1:0] op, input int i, input logic v);
    wb(1'b1, 4'h4, {26'h3ffffff, op, v, i[2:0]});
    poll(4'h8, 0);
  endtask : cmd
  task automatic t_reset;
    wb(1'b0, 4'h0, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'hc);
    wb(1'b1, 4'h2, 32'hffffffff);
    wb(1'b0, 4'h2, 32'h0);
    chk(q, 32'h0);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_init;
    wb(1'b1, 4'h0, 32'h2);
    poll(4'h0, 1);
    for (int i = 0; i < 8; i++) begin
      i_dps_sem_model.write_r(i, 1'b1);
    end
    chk(i_dps_sem_model.req_l, 32'hff);
    for (int i = 0; i < 8; i++) begin
      cmd(2'h1, i, 1'b0);
      wb(1'b0, 4'hc, 32'h0);
      chk(q, 32'h1);
    end
    $display("t_init done");
  endtask : t_init
  task automatic t_claim;
    for (int i = 0; i < 8; i++) begin
      cmd(2'h2, i, 1'b0);
      wb(1'b0, 4'hc, 32'h0);
      chk(q, 32'h0);
      chk(i_dps_sem_model.flag_r(i), 32'h1);
      cmd(2'h0, i, 1'b1);
      chk(i_dps_sem_model.own_l, 32'h0);
      chk(i_dps_sem_model.busy_l_n, 32'h1);
    end
    $display("t_claim done");
  endtask : t_claim
  task automatic t_contend;
    cmd(2'h2, 3, 1'b0);
    i_dps_sem_model.write_r(3, 1'b0);
    chk(i_dps_sem_model.flag_r(3), 32'h1);
    cmd(2'h0, 3, 1'b1);
    chk(i_dps_sem_model.flag_r(3), 32'h0);
    cmd(2'h2, 3, 1'b0);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h1);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[1], 32'h0);
    cmd(2'h0, 3, 1'b1);
    i_dps_sem_model.write_r(3, 1'b1);
    chk(i_dps_sem_model.own_l[3], 32'h0);
    cmd(2'h1, 3, 1'b0);
    wb(1'b0, 4'hc, 32'h0);
    chk(q, 32'h1);
    $display("t_contend done");
  endtask : t_contend
  task automatic t_pins;
    busy_n_i <= 1'b0;
    // two-flop synchroniser on the busy pin
    repeat (3) @(posedge core_clk);
    wb(1'b0, 4'h8, 32'h0);
    chk(q[2], 32'h0);
    busy_n_i <= 1'b1;
    wb(1'b1, 4'h0, 32'h1);
    chk(master_strap, 32'h1);
    wb(1'b1, 4'h0, 32'h0);
    // second command lands while the first is busy and must be dropped
    wb(1'b1, 4'h4, 32'h26);
    wb(1'b1, 4'h4, 32'h0e);
    poll(4'h8, 0);
    chk(i_dps_sem_model.own_l[6], 32'h1);
    cmd(2'h0, 6, 1'b1);
    $display("t_pins done");
  endtask : t_pins
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_init();
    t_claim();
    t_contend();
    t_pins();
    test_done();
  end
endmodule : tb_dps_host
bind dps_host dps_host_properties #(.DW(DW)) i_dps_host_properties (.*);

// >>> hdl/dps_consts.svh
// constants for the semaphore port controller
`ifndef DPS_CONSTS_SVH
`define DPS_CONSTS_SVH
`define DPS_OFF_CTRL 4'h0
`define DPS_OFF_CMD 4'h4
`define DPS_OFF_STAT 4'h8
`define DPS_OFF_RDATA 4'hc
`define DPS_CMD_IDX_LSB 0
`define DPS_CMD_VAL_BIT 3
`define DPS_CMD_OP_LSB 4
`define DPS_CTRL_MASTER_BIT 0
`define DPS_CTRL_INIT_BIT 1
`define DPS_STAT_BUSY_BIT 0
`define DPS_STAT_OWN_BIT 1
`define DPS_STAT_BUSYIN_BIT 2
`define DPS_STAT_STBY_BIT 3
`define DPS_SETUP_NS 20
`define DPS_PULSE_NS 20
`define DPS_CLK_NS 5
`define DPS_SETUP_CYC ((`DPS_SETUP_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_PULSE_CYC ((`DPS_PULSE_NS + `DPS_CLK_NS - 1) / `DPS_CLK_NS)
`define DPS_NSEM 8
`endif

// >>> hdl/dps_host.sv
// wishbone-controlled host for one port of a semaphore dual-port memory
`include "dps_consts.svh"
module dps_host #(
  parameter int DW = 18,
  parameter int SETUP_CYC = `DPS_SETUP_CYC,
  parameter int PULSE_CYC = `DPS_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic semaphore_select_n,
  output logic ce_n,
  output logic rw_n,
  output logic oe_n,
  output logic [1:0] byte_lane_selects_n,
  output logic [2:0] semaphore_index_lines,
  output logic [DW-1:0] data_o,
  output logic [DW-1:0] data_oe,
  input wire logic [DW-1:0] data_i,
  input wire logic busy_n_i,
  output logic master_strap
);
  dps_seq_if sq ();
  logic [DW-1:0] din_s1_r;
  logic [DW-1:0] din_s2_r;
  logic busy_s1_r;
  logic busy_s2_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic master_r;
  logic busy_r;
  logic owned_r;
  logic last_flag_r;
  logic start_r;
  dps_pkg::dps_op_t op_r;
  logic [2:0] idx_r;
  logic val_r;
  logic claim_rd_r;
  logic init_r;
  logic [3:0] init_cnt_r;
  logic seq_data_oe;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      din_s1_r <= '1;
      din_s2_r <= '1;
      busy_s1_r <= 1'b1;
      busy_s2_r <= 1'b1;
    end else begin
      din_s1_r <= data_i;
      din_s2_r <= din_s1_r;
      busy_s1_r <= busy_n_i;
      busy_s2_r <= busy_s1_r;
    end
  end

  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] off);
    reg_hit = (adr == off);
  endfunction : reg_hit

  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_r;

  // wishbone slave: answer one cycle after request, ack dropped next cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      ack_r <= wb_req;
      if (wb_req) begin
        if (reg_hit(wb_adr_i, `DPS_OFF_CTRL)) begin
          rdat_r <= {30'h0, init_r, master_r};
        end else if (reg_hit(wb_adr_i, `DPS_OFF_STAT)) begin
          rdat_r <= {28'h0, semaphore_select_n & ce_n, busy_s2_r, owned_r, busy_r};
        end else if (reg_hit(wb_adr_i, `DPS_OFF_RDATA)) begin
          rdat_r <= {31'h0, last_flag_r};
        end else begin
          rdat_r <= 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      master_r <= 1'b0;
    end else if (wb_req && wb_we_i && wb_sel_i[0] && reg_hit(wb_adr_i, `DPS_OFF_CTRL)) begin
      master_r <= wb_dat_i[`DPS_CTRL_MASTER_BIT];
    end
  end

  // command launch, claim follow-up read and power-up release walk
  always_ff @(posedge core_clk) begin
    if (rst) begin
      start_r <= 1'b0;
      op_r <= dps_pkg::DPS_OP_WRITE;
      idx_r <= 3'h0;
      val_r <= 1'b1;
      busy_r <= 1'b0;
      claim_rd_r <= 1'b0;
      init_r <= 1'b0;
      init_cnt_r <= 4'h0;
    end else begin
      start_r <= 1'b0;
      if (!busy_r && wb_req && wb_we_i && wb_sel_i[0] &&
          reg_hit(wb_adr_i, `DPS_OFF_CMD)) begin
        busy_r <= 1'b1;
        start_r <= 1'b1;
        idx_r <= wb_dat_i[`DPS_CMD_IDX_LSB +: 3];
        val_r <= wb_dat_i[`DPS_CMD_VAL_BIT];
        // op 3 has no meaning of its own and runs as a plain write
        case (wb_dat_i[`DPS_CMD_OP_LSB +: 2])
          2'b01: op_r <= dps_pkg::DPS_OP_READ;
          2'b10: begin
            op_r <= dps_pkg::DPS_OP_WRITE;
            val_r <= 1'b0;
            claim_rd_r <= 1'b1;
          end
          default: op_r <= dps_pkg::DPS_OP_WRITE;
        endcase
      end else if (!busy_r && wb_req && wb_we_i && wb_sel_i[0] &&
                   reg_hit(wb_adr_i, `DPS_OFF_CTRL) && wb_dat_i[`DPS_CTRL_INIT_BIT]) begin
        busy_r <= 1'b1;
        init_r <= 1'b1;
        init_cnt_r <= 4'h0;
        start_r <= 1'b1;
        op_r <= dps_pkg::DPS_OP_WRITE;
        idx_r <= 3'h0;
        val_r <= 1'b1;
      end else if (busy_r && sq.done) begin
        if (claim_rd_r) begin
          claim_rd_r <= 1'b0;
          start_r <= 1'b1;
          op_r <= dps_pkg::DPS_OP_READ;
        end else if (init_r && init_cnt_r != 4'(`DPS_NSEM - 1)) begin
          init_cnt_r <= init_cnt_r + 4'h1;
          idx_r <= idx_r + 3'h1;
          start_r <= 1'b1;
        end else begin
          init_r <= 1'b0;
          busy_r <= 1'b0;
        end
      end
    end
  end

  // ownership is set by a read back only and cleared by a read or a write of one: a write of zero may have
  // landed in the request latch while the far port still holds the token
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_flag_r <= 1'b1;
      owned_r <= 1'b0;
    end else if (sq.done && op_r == dps_pkg::DPS_OP_READ) begin
      last_flag_r <= sq.flag;
      owned_r <= ~sq.flag;
    end else if (sq.done && op_r == dps_pkg::DPS_OP_WRITE && val_r) begin
      owned_r <= 1'b0;
    end
  end

  assign sq.start = start_r;
  assign sq.op = op_r;
  assign sq.idx = idx_r;
  assign sq.val = val_r;

  dps_pin_seq #(
    .SETUP_CYC(SETUP_CYC),
    .PULSE_CYC(PULSE_CYC),
    .DW(DW)
  ) u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .sq(sq),
    .pin_data_sync(din_s2_r),
    .semaphore_select_n(semaphore_select_n),
    .ce_n(ce_n),
    .rw_n(rw_n),
    .oe_n(oe_n),
    .byte_lane_selects_n(byte_lane_selects_n),
    .semaphore_index_lines(semaphore_index_lines),
    .data_out(data_o),
    .data_oe(seq_data_oe)
  );

  assign data_oe = {DW{seq_data_oe}};
  assign master_strap = master_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
endmodule : dps_host

// >>> hdl/dps_pin_seq.sv
// pin-level sequencer for one semaphore write or read cycle
`include "dps_consts.svh"
module dps_pin_seq #(
  parameter int SETUP_CYC = `DPS_SETUP_CYC,
  parameter int PULSE_CYC = `DPS_PULSE_CYC,
  parameter int DW = 18
) (
  input wire logic core_clk,
  input wire logic rst,
  dps_seq_if.seq sq,
  input wire logic [DW-1:0] pin_data_sync,
  output logic semaphore_select_n,
  output logic ce_n,
  output logic rw_n,
  output logic oe_n,
  output logic [1:0] byte_lane_selects_n,
  output logic [2:0] semaphore_index_lines,
  output logic [DW-1:0] data_out,
  output logic data_oe
);
  dps_pkg::dps_state_t state_r;
  logic [7:0] cnt_r;
  logic is_read_r;
  logic done_r;
  logic flag_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= dps_pkg::DPS_IDLE;
      cnt_r <= 8'h00;
      is_read_r <= 1'b0;
    end else begin
      case (state_r)
        dps_pkg::DPS_IDLE: begin
          cnt_r <= 8'h00;
          if (sq.start) begin
            is_read_r <= (sq.op == dps_pkg::DPS_OP_READ);
            state_r <= (sq.op == dps_pkg::DPS_OP_READ) ? dps_pkg::DPS_RSETUP
                                                      : dps_pkg::DPS_SETUP;
          end
        end
        dps_pkg::DPS_SETUP: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(SETUP_CYC - 1)) begin
            cnt_r <= 8'h00;
            state_r <= dps_pkg::DPS_PULSE;
          end
        end
        dps_pkg::DPS_PULSE: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(PULSE_CYC - 1)) begin
            cnt_r <= 8'h00;
            state_r <= dps_pkg::DPS_RECOV;
          end
        end
        dps_pkg::DPS_RSETUP: begin
          // two sync stages plus access time before sampling
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(PULSE_CYC + 1)) begin
            state_r <= dps_pkg::DPS_RSAMPLE;
          end
        end
        dps_pkg::DPS_RSAMPLE: begin
          state_r <= dps_pkg::DPS_RECOV;
        end
        dps_pkg::DPS_RECOV: begin
          // select released here after a write, in RSAMPLE after a read, so the next read relatches the flag
          state_r <= dps_pkg::DPS_IDLE;
        end
        default: state_r <= dps_pkg::DPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_r <= 1'b0;
      flag_r <= 1'b1;
    end else begin
      done_r <= (state_r == dps_pkg::DPS_RSAMPLE) ||
                (state_r == dps_pkg::DPS_PULSE && cnt_r == 8'(PULSE_CYC - 1));
      if (state_r == dps_pkg::DPS_RSAMPLE) begin
        flag_r <= &pin_data_sync;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      semaphore_select_n <= 1'b1;
      ce_n <= 1'b1;
      rw_n <= 1'b1;
      oe_n <= 1'b1;
      byte_lane_selects_n <= 2'b11;
      semaphore_index_lines <= 3'h0;
      data_out <= '1;
      data_oe <= 1'b0;
    end else begin
      ce_n <= 1'b1;
      if (state_r == dps_pkg::DPS_IDLE && sq.start) begin
        semaphore_select_n <= 1'b0;
        semaphore_index_lines <= sq.idx;
        byte_lane_selects_n <= 2'b00;
        data_out <= {{(DW-1){1'b1}}, sq.val};
        data_oe <= (sq.op != dps_pkg::DPS_OP_READ);
        oe_n <= ~(sq.op == dps_pkg::DPS_OP_READ);
      end else if (state_r == dps_pkg::DPS_SETUP && cnt_r == 8'(SETUP_CYC - 1)) begin
        rw_n <= 1'b0;
      end else if (state_r == dps_pkg::DPS_PULSE && cnt_r == 8'(PULSE_CYC - 1)) begin
        rw_n <= 1'b1;
      end else if (state_r == dps_pkg::DPS_RSAMPLE ||
                   (state_r == dps_pkg::DPS_RECOV && !is_read_r)) begin
        semaphore_select_n <= 1'b1;
        oe_n <= 1'b1;
        byte_lane_selects_n <= 2'b11;
        data_oe <= 1'b0;
      end
    end
  end

  assign sq.done = done_r;
  assign sq.flag = flag_r;
endmodule : dps_pin_seq

// >>> hdl/dps_pkg.sv
// types for the semaphore port controller
package dps_pkg;
  typedef enum logic [2:0] {
    DPS_IDLE = 3'b000,
    DPS_SETUP = 3'b001,
    DPS_PULSE = 3'b010,
    DPS_RECOV = 3'b011,
    DPS_RSETUP = 3'b100,
    DPS_RSAMPLE = 3'b101
  } dps_state_t;
  typedef enum logic [1:0] {
    DPS_OP_WRITE = 2'b00,
    DPS_OP_READ = 2'b01,
    DPS_OP_CLAIM = 2'b10
  } dps_op_t;
endpackage : dps_pkg

// >>> hdl/dps_seq_if.sv
// request/answer link between the register front end and the pin sequencer
interface dps_seq_if;
  logic start;
  dps_pkg::dps_op_t op;
  logic [2:0] idx;
  logic val;
  logic done;
  logic flag;
  modport front (output start, output op, output idx, output val, input done, input flag);
  modport seq (input start, input op, input idx, input val, output done, output flag);
endinterface : dps_seq_if
